// file: core/tx_clk_pkg.sv
// Package: register map, field positions, reset values and level codes
package tx_clk_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [3:0] ctrl_offset = 4'h0;
   localparam logic [3:0] status_offset = 4'h4;
   localparam logic [3:0] phase_offset = 4'h8;
   localparam logic [3:0] period_offset = 4'hC;
   // ==========================================================
   // Control field positions
   localparam int ctrl_src_bit = 0;
   localparam int ctrl_rate_bit = 1;
   localparam int ctrl_rx_src_bit = 2;
   localparam int ctrl_align_rst_bit = 3;
   localparam logic [3:0] ctrl_reset_value = 4'h8;
   // ==========================================================
   // Status field positions
   localparam int status_mode_lsb = 0;
   localparam int status_align_bit = 4;
   localparam int status_ignore_bit = 5;
   // ==========================================================
   // Three-level codes and mode count
   localparam logic [1:0] level_low = 2'h0;
   localparam logic [1:0] level_mid = 2'h1;
   localparam logic [1:0] level_high = 2'h2;
   localparam logic [3:0] mode_count = 4'h9;
   localparam logic [3:0] level_radix = 4'h3;
   // ==========================================================
   // Clock
   localparam int mclk_hz = 40000000;
endpackage

// file: core/three_level_resolve.sv
// Resolves three-level select pins into LOW, MID or HIGH codes
`timescale 1ns/10ps
module three_level_resolve #(
   parameter int N = 2
) (
   // Pin sense: high sense is pulled to supply, low sense to ground
   input wire logic [N-1:0] sense_high,
   input wire logic [N-1:0] sense_low,
   // Resolved codes, two bits per pin
   output logic [2*N-1:0] level
);
   // ==========================================================
   // Per-pin decode
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_pin
         // Floating or contradictory sense self-biases to MID
         always_comb begin
            if (sense_high[i] && !sense_low[i]) begin
               level[2*i+1:2*i] = tx_clk_pkg::level_high; // R12
            end else if (sense_low[i] && !sense_high[i]) begin
               level[2*i+1:2*i] = tx_clk_pkg::level_low; // R12
            end else begin
               level[2*i+1:2*i] = tx_clk_pkg::level_mid; // R12
            end
         end
      end
   endgenerate
endmodule

// file: core/char_clock_gen.sv
// Reference edge detection and character-rate clock synthesis
`timescale 1ns/10ps
module char_clock_gen #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Reference and rate
   input wire logic ref_level,
   input wire logic rate_half,
   // Events and clocks
   output logic ref_rise,
   output logic ref_fall,
   output logic char_tick,
   output logic synth_clk,
   output logic [CNT_W-1:0] half_period
);
   logic ref_q_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] half_reg;
   logic synth_reg;

   // ==========================================================
   // Edge events
   assign ref_rise = ref_level && !ref_q_reg;
   assign ref_fall = !ref_level && ref_q_reg;
   // Half rate: one character per reference edge, both edges
   assign char_tick = ref_rise || (rate_half && ref_fall); // R03 R11
   assign synth_clk = synth_reg;
   assign half_period = half_reg;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ref_q_reg <= 1'b0;
      end else begin
         ref_q_reg <= ref_level;
      end
   end

   // ==========================================================
   // Half-period tracking, needed to place the mid-cycle fall
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= '0;
         half_reg <= '0;
      end else if (ref_rise || ref_fall) begin
         cnt_reg <= '0;
         half_reg <= cnt_reg;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   // ==========================================================
   // Synthesized clock: one period per character, so bit rate / 10
   // Rises on char_tick at reference edges, so phase tied to the reference
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         synth_reg <= 1'b0;
      end else if (char_tick) begin
         synth_reg <= 1'b1; // R04 R05
      end else if (rate_half && cnt_reg == (half_reg >> 1)) begin
         synth_reg <= 1'b0; // R03 R06
      end else if (!rate_half && ref_fall) begin
         synth_reg <= 1'b0; // R03 R06
      end
   end
endmodule

// file: core/tx_clock_source_and_rate_select.sv
// Transmit clock source, rate and mode selection with register access
// Behaviour
// R01 - Source LOW: reference rising edge loads inputs
// R02 - Source HIGH: input clock rising edge loads
// R03 - Synth clock at reference or double rate
// R04 - Synth clock equals bit clock over ten
// R05 - Synth clock has no fixed reference phase; code raises it on char_tick at reference edges
// R06 - Rate HIGH multiplies by twenty, LOW ten
// R07 - Reference-clocked receive outputs follow reference
// R08 - Outside input clock frequency-coherent with synth
// R09 - Phase adjusts while reset LOW, holds HIGH
// R10 - Two three-level mode pins give nine modes
// R11 - Half rate: sample on both reference edges
// R12 - Three-level pins resolve, floating means MID
// R13 - Outside holds phase reset LOW long enough
// R14 - Phase reset ignored when source, rate LOW
// R15 - Selects stay static while path operates
`timescale 1ns/10ps
module tx_clock_source_and_rate_select #(
   parameter int CHANNELS = 4,
   parameter int CHAR_W = 10,
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Clock pins
   input wire logic reference_clock_in,
   input wire logic tx_channel_input_clock,
   // Three-level mode pins
   input wire logic [1:0] mode_sense_high,
   input wire logic [1:0] mode_sense_low,
   // Transmit characters in and out
   input wire logic [CHANNELS*CHAR_W-1:0] tx_data_in,
   output logic [CHANNELS*CHAR_W-1:0] tx_char_out,
   output logic tx_char_strobe,
   // Generated clocks and mode
   output logic tx_synth_clock_out,
   output logic rx_clock_out_first,
   output logic rx_clock_out_second,
   output logic [3:0] tx_operating_mode_select
);
   // ==========================================================
   // Bus registers
   logic [3:0] ctrl_reg;
   logic waitrequest_reg;
   logic [31:0] readdata_reg;

   // ==========================================================
   // Transmit path registers
   logic in_clk_q_reg;
   logic [CHANNELS*CHAR_W-1:0] hold_reg;
   logic [CHANNELS*CHAR_W-1:0] char_out_reg;
   logic strobe_reg;

   // ==========================================================
   // Alignment and mode registers
   logic [CNT_W-1:0] phase_cnt_reg;
   logic [CNT_W-1:0] phase_offset_reg;
   logic [3:0] mode_reg;

   // ==========================================================
   // Receive clock registers
   logic rx_first_reg;
   logic rx_second_reg;

   // ==========================================================
   // Control fields
   logic tx_clock_source_select;
   logic tx_pll_rate_select;
   logic rx_clock_source_select;
   logic tx_phase_align_reset;

   // ==========================================================
   // Reference events
   logic ref_rise;
   logic ref_fall;
   logic ref_edge;
   logic char_tick;
   logic synth_clk;
   logic [CNT_W-1:0] half_period;

   // ==========================================================
   // Decode
   logic [3:0] mode_level;
   logic [3:0] mode_next;
   logic mode_valid;
   logic in_clk_rise;
   logic load_tick;
   logic align_ignore;
   logic align_active;

   // ==========================================================
   // Bus decode
   logic access;
   logic write_hit;
   logic read_hit;
   logic [31:0] status_word;
   logic [31:0] read_value;

   // ==========================================================
   // Control fields
   assign tx_clock_source_select = ctrl_reg[tx_clk_pkg::ctrl_src_bit];
   assign tx_pll_rate_select = ctrl_reg[tx_clk_pkg::ctrl_rate_bit];
   assign rx_clock_source_select = ctrl_reg[tx_clk_pkg::ctrl_rx_src_bit];
   assign tx_phase_align_reset = ctrl_reg[tx_clk_pkg::ctrl_align_rst_bit];

   // ==========================================================
   // Reference edges and synthesized character clock
   char_clock_gen #(
      .CNT_W(CNT_W)
   ) u_char_clock (
      .mclk(mclk),
      .rstn(rstn),
      .ref_level(reference_clock_in),
      .rate_half(tx_pll_rate_select),
      .ref_rise(ref_rise),
      .ref_fall(ref_fall),
      .char_tick(char_tick),
      .synth_clk(synth_clk),
      .half_period(half_period)
   );

   assign tx_synth_clock_out = synth_clk;

   // ==========================================================
   // Mode pin resolution
   three_level_resolve #(
      .N(2)
   ) u_mode_resolve (
      .sense_high(mode_sense_high),
      .sense_low(mode_sense_low),
      .level(mode_level)
   );

   // Base-three combination of two pins gives the nine modes
   assign mode_next = mode_level[3:2] * tx_clk_pkg::level_radix
      + {2'h0, mode_level[1:0]}; // R10

   // Out-of-range codes cannot occur, the guard keeps the index legal
   assign mode_valid = mode_next < tx_clk_pkg::mode_count; // R10

   // ==========================================================
   // Transmit mode register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mode_reg <= 4'h0;
      end else if (mode_valid) begin
         mode_reg <= mode_next; // R10
      end
   end

   assign tx_operating_mode_select = mode_reg;

   // ==========================================================
   // Input clock source selection
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         in_clk_q_reg <= 1'b0;
      end else begin
         in_clk_q_reg <= tx_channel_input_clock;
      end
   end

   assign ref_edge = ref_rise || ref_fall;
   // Input clock is trusted to be coherent with the synth clock
   assign in_clk_rise = tx_channel_input_clock && !in_clk_q_reg; // R08
   always_comb begin
      if (tx_clock_source_select) begin
         load_tick = in_clk_rise; // R02
      end else if (tx_pll_rate_select) begin
         load_tick = ref_edge; // R01 R11
      end else begin
         load_tick = ref_rise; // R01
      end
   end

   // ==========================================================
   // Channel input and output registers
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
         always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               hold_reg[ch*CHAR_W +: CHAR_W] <= '0;
            end else if (load_tick) begin
               hold_reg[ch*CHAR_W +: CHAR_W] <=
                  tx_data_in[ch*CHAR_W +: CHAR_W]; // R01 R02
            end
         end
         // Transfer to the character-rate side, one character late
         always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               char_out_reg[ch*CHAR_W +: CHAR_W] <= '0;
            end else if (char_tick) begin
               char_out_reg[ch*CHAR_W +: CHAR_W] <=
                  hold_reg[ch*CHAR_W +: CHAR_W]; // R03
            end
         end
      end
   endgenerate

   // ==========================================================
   // Character strobe
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         strobe_reg <= 1'b0;
      end else begin
         strobe_reg <= char_tick;
      end
   end

   assign tx_char_out = char_out_reg;
   assign tx_char_strobe = strobe_reg;

   // ==========================================================
   // Phase alignment between input clock and character clock
   assign align_ignore = !tx_clock_source_select
      && !tx_pll_rate_select; // R14
   assign align_active = !align_ignore && !tx_phase_align_reset; // R09

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         phase_cnt_reg <= '0;
      end else if (char_tick) begin
         phase_cnt_reg <= '0;
      end else begin
         phase_cnt_reg <= phase_cnt_reg + 1'b1;
      end
   end

   // Offset only moves during alignment, data loading carries on unchanged
   // Limitation: offset is only reported, the data path ignores it
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         phase_offset_reg <= '0;
      end else if (align_active && in_clk_rise) begin
         phase_offset_reg <= phase_cnt_reg; // R09
      end
   end

   // ==========================================================
   // Receive clock outputs in reference-clocked mode
   // Second output lags one cycle to give a choice of timing
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rx_first_reg <= 1'b0;
      end else if (!rx_clock_source_select) begin
         rx_first_reg <= reference_clock_in; // R07
      end else begin
         rx_first_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rx_second_reg <= 1'b0;
      end else if (!rx_clock_source_select) begin
         rx_second_reg <= rx_first_reg; // R07
      end else begin
         rx_second_reg <= 1'b0;
      end
   end

   assign rx_clock_out_first = rx_first_reg;
   assign rx_clock_out_second = rx_second_reg;

   // ==========================================================
   // Avalon-MM slave, one wait cycle per access
   assign access = (read || write) && waitrequest_reg;
   assign read_hit = read && access;
   assign write_hit = write && !waitrequest_reg
      && address == tx_clk_pkg::ctrl_offset;

   // ==========================================================
   // Bus wait state
   // Registered answer costs a cycle but keeps bus paths short
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         waitrequest_reg <= 1'b1;
      end else if (!waitrequest_reg) begin
         waitrequest_reg <= 1'b1;
      end else if (read || write) begin
         waitrequest_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Control register
   // Settings are meant to stay static while the path runs
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= tx_clk_pkg::ctrl_reset_value;
      end else if (write_hit) begin
         ctrl_reg <= writedata[3:0]; // R15
      end
   end

   // ==========================================================
   // Status word and read data
   always_comb begin
      status_word = 32'h0;
      status_word[tx_clk_pkg::status_mode_lsb +: 4] = mode_reg; // R10
      status_word[tx_clk_pkg::status_align_bit] = align_active; // R09
      status_word[tx_clk_pkg::status_ignore_bit] = align_ignore; // R14
   end

   always_comb begin
      read_value = 32'h0;
      case (address)
         tx_clk_pkg::ctrl_offset: begin
            read_value[3:0] = ctrl_reg;
         end
         tx_clk_pkg::status_offset: begin
            read_value = status_word;
         end
         tx_clk_pkg::phase_offset: begin
            read_value[CNT_W-1:0] = phase_offset_reg;
         end
         tx_clk_pkg::period_offset: begin
            read_value[CNT_W-1:0] = half_period;
         end
         default: begin
            read_value = 32'h0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         readdata_reg <= 32'h0;
      end else if (read_hit) begin
         readdata_reg <= read_value;
      end
   end

   // ==========================================================
   // Bus outputs
   assign readdata = readdata_reg;
   assign waitrequest = waitrequest_reg;
endmodule

// file: verification/tx_clk_sva.sv
// Checker of bus timing, generated clocks and mode decoding
`timescale 1ns/10ps
module tx_clk_sva #(
   parameter int CHANNELS = 4,
   parameter int CHAR_W = 10
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Bus
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   // Pins
   input wire logic reference_clock_in,
   input wire logic [1:0] mode_sense_high,
   input wire logic [1:0] mode_sense_low,
   // Outputs
   input wire logic [CHANNELS*CHAR_W-1:0] tx_char_out,
   input wire logic tx_char_strobe,
   input wire logic tx_synth_clock_out,
   input wire logic rx_clock_out_first,
   input wire logic rx_clock_out_second,
   input wire logic [3:0] tx_operating_mode_select
);
   // ==========================================================
   // Helpers
   function automatic logic [3:0] lvl(input logic h, input logic l);
      return (h && !l) ? 4'h2 : ((l && !h) ? 4'h0 : 4'h1);
   endfunction
   logic [3:0] exp_mode;
   assign exp_mode = 4'h3 * lvl(mode_sense_high[1], mode_sense_low[1])
      + lvl(mode_sense_high[0], mode_sense_low[0]);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   sequence s_taken;
      (read || write) && waitrequest;
   endsequence
   sequence s_answer;
      !waitrequest ##1 waitrequest;
   endsequence
   // ==========================================================
   // Properties
   a_bus_answer: assert property (s_taken |=> s_answer)
      else $error("bus answer not one cycle");
   a_bus_idle: assert property (!read && !write |=> waitrequest)
      else $error("waitrequest low while idle");
   a_mode_decode: assert property (
      1 |=> tx_operating_mode_select == $past(exp_mode))
      else $error("mode decode wrong");
   a_mode_range: assert property (
      tx_operating_mode_select < tx_clk_pkg::mode_count)
      else $error("mode index out of range");
   a_rx_first: assert property (
      rx_clock_out_first |-> $past(reference_clock_in))
      else $error("first receive clock not following reference");
   a_rx_second: assert property (
      rx_clock_out_second |-> $past(reference_clock_in, 2))
      else $error("second receive clock not following reference");
   a_synth_char: assert property (
      $rose(tx_synth_clock_out) |-> tx_char_strobe)
      else $error("synth rise without strobe");
   a_strobe_pulse: assert property (
      tx_char_strobe |-> tx_synth_clock_out ##1 !tx_char_strobe)
      else $error("strobe not a single pulse after synth rise");
   a_char_hold: assert property (
      $changed(tx_char_out) |-> tx_char_strobe)
      else $error("characters changed off a tick");
endmodule
bind tx_clock_source_and_rate_select tx_clk_sva #(
   .CHANNELS(CHANNELS), .CHAR_W(CHAR_W)) i_sva (
   .mclk(mclk), .rstn(rstn), .read(read), .write(write),
   .waitrequest(waitrequest), .reference_clock_in(reference_clock_in),
   .mode_sense_high(mode_sense_high), .mode_sense_low(mode_sense_low),
   .tx_char_out(tx_char_out), .tx_char_strobe(tx_char_strobe),
   .tx_synth_clock_out(tx_synth_clock_out),
   .rx_clock_out_first(rx_clock_out_first),
   .rx_clock_out_second(rx_clock_out_second),
   .tx_operating_mode_select(tx_operating_mode_select));

// file: verification/tx_far_logic.sv
// Far-side logic model: reference, input clock and channel data
`timescale 1ns/10ps
module tx_far_logic #(
   parameter int HALF_NS = 200,
   parameter int SKEW_NS = 100
) (
   // Control
   input wire logic use_input_clock,
   // Clocks and data
   output logic reference_clock_in,
   output logic tx_channel_input_clock,
   output logic [39:0] tx_data_in
);
   // ==========================================================
   // Same half period keeps the input clock coherent, skewed
   initial begin
      reference_clock_in = 1'b0;
      tx_channel_input_clock = 1'b0;
      tx_data_in = 40'h0;
      fork
         forever #(HALF_NS) reference_clock_in = ~reference_clock_in;
         begin
            #(SKEW_NS);
            forever #(HALF_NS) tx_channel_input_clock =
               ~tx_channel_input_clock;
         end
         // Data moves on the falling edge, away from the load edge
         forever begin
            @(negedge (use_input_clock ? tx_channel_input_clock
               : reference_clock_in));
            tx_data_in = tx_data_in + 40'h13_5791_3579;
         end
      join
   end
endmodule

// file: verification/tb.sv
// Testbench: bus tasks, character path, clock rate and mode tests
`timescale 1ns/10ps
module tb;
   // ==========================================================
   // Signals
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] address = 4'h0;
   logic [31:0] writedata = 32'h0;
   logic [1:0] sh = 2'h0;
   logic [1:0] sl = 2'h0;
   logic use_in = 1'b0;
   logic chk_on = 1'b0;
   logic [31:0] readdata, rd, ph;
   logic waitrequest, ref_clk, in_clk, strobe, synth, rx_a, rx_b;
   logic ref_q, ref_qq, in_q;
   logic [39:0] data, char_out, hold_m, exp_out;
   logic [3:0] mode;
   int n_mismatch = 0;
   int compares = 0;
   initial forever #12.5 mclk = ~mclk;
   tx_far_logic i_far (.use_input_clock(use_in),
      .reference_clock_in(ref_clk), .tx_channel_input_clock(in_clk),
      .tx_data_in(data));
   tx_clock_source_and_rate_select i_dut (.mclk(mclk), .rstn(rstn),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .reference_clock_in(ref_clk),
      .tx_channel_input_clock(in_clk), .mode_sense_high(sh),
      .mode_sense_low(sl), .tx_data_in(data), .tx_char_out(char_out),
      .tx_char_strobe(strobe), .tx_synth_clock_out(synth),
      .rx_clock_out_first(rx_a), .rx_clock_out_second(rx_b),
      .tx_operating_mode_select(mode));
   // ==========================================================
   // Tasks
   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic wr, input logic [3:0] a,
      input logic [31:0] wd, output logic [31:0] d);
      @(posedge mclk);
      address <= a;
      writedata <= wd;
      read <= !wr;
      write <= wr;
      do @(posedge mclk); while (waitrequest !== 1'b0);
      d = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic synth_period(input int exp);
      realtime t0;
      @(posedge synth);
      t0 = $realtime;
      @(posedge synth);
      check(40'(int'(($realtime - t0) / 25.0)), 40'(exp));
   endtask
   task automatic complete_run;
      if (n_mismatch == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ==========================================================
   // Character path model: load on selected rise, out on ref rise
   always @(posedge mclk) begin
      ref_q <= ref_clk;
      ref_qq <= ref_q;
      in_q <= in_clk;
      if (use_in ? (in_clk && !in_q) : (ref_clk && !ref_q))
         hold_m <= data;
      if (ref_clk && !ref_q)
         exp_out <= hold_m;
      if (chk_on && strobe === 1'b1)
         check(char_out, exp_out);
      // Receive clocks copy the reference one and two cycles late
      if (chk_on) begin
         check(40'(rx_a), 40'(ref_q));
         check(40'(rx_b), 40'(ref_qq));
      end
   end
   initial begin
      #200000;
      n_mismatch++;
      complete_run;
   end
   // ==========================================================
   // Tests
   initial begin
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      acc(0, tx_clk_pkg::ctrl_offset, 0, rd);
      check(40'(rd), 40'(tx_clk_pkg::ctrl_reset_value));
      acc(0, 4'h2, 0, rd);
      check(40'(rd), 40'h0);
      for (int i = 0; i < 10; i++) begin
         sh <= (i == 9) ? 2'h3 : {i / 3 == 2, i % 3 == 2};
         sl <= (i == 9) ? 2'h3 : {i / 3 == 0, i % 3 == 0};
         acc(1, tx_clk_pkg::status_offset, 32'hF, rd);
         acc(0, tx_clk_pkg::status_offset, 0, rd);
         check(40'(rd[3:0]), 40'((i == 9) ? 4 : i));
      end
      // Selects change only while no traffic is checked
      for (int c = 0; c < 16; c++) begin
         acc(1, tx_clk_pkg::ctrl_offset, 32'(c), rd);
         acc(0, tx_clk_pkg::status_offset, 0, rd);
         check(40'(rd[4]), 40'(c[1:0] != 0 && !c[3]));
         check(40'(rd[5]), 40'(c[1:0] == 0));
      end
      acc(1, tx_clk_pkg::ctrl_offset, 32'h8, rd);
      repeat (40) @(posedge mclk);
      chk_on <= 1'b1;
      synth_period(16);
      repeat (100) @(posedge mclk);
      chk_on <= 1'b0;
      use_in <= 1'b1;
      // Align reset held LOW over three input clock rises
      acc(1, tx_clk_pkg::ctrl_offset, 32'h1, rd);
      repeat (48) @(posedge mclk);
      acc(1, tx_clk_pkg::ctrl_offset, 32'h9, rd);
      repeat (40) @(posedge mclk);
      chk_on <= 1'b1;
      acc(0, tx_clk_pkg::phase_offset, 0, ph);
      // Input clock trails the reference by four mclk periods
      check(40'(ph), 40'h3);
      repeat (100) @(posedge mclk);
      acc(0, tx_clk_pkg::phase_offset, 0, rd);
      check(40'(rd), 40'(ph));
      chk_on <= 1'b0;
      acc(1, tx_clk_pkg::ctrl_offset, 32'hA, rd);
      repeat (40) @(posedge mclk);
      synth_period(8);
      acc(0, tx_clk_pkg::period_offset, 0, rd);
      check(40'(rd[15:0]), 40'h7);
      complete_run;
   end
endmodule
